// file: mie_pkg.sv
package mie_pkg;
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_ACC   = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_PC    = 12'h00c;
    localparam logic [11:0] OFS_PUSH  = 12'h010;
    localparam logic [11:0] OFS_MEM   = 12'h100;
    localparam int FB_C = 0;
    localparam int FB_AC = 1;
    localparam int FB_Z = 2;
    localparam int FB_TO = 4;
    localparam int FB_PDF = 5;
    localparam int FB_EMI = 6;
    localparam int FB_PRE_A = 8;
    localparam int FB_PRE_B = 9;
    localparam int FB_HALT = 10;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_PRE_A = 5'h01, OP_PRE_B = 5'h02, OP_CPL = 5'h03,
        OP_ONES_COMPLEMENT_TO_ACC = 5'h04, OP_DAA = 5'h05, OP_DEC = 5'h06, OP_DECREMENT_TO_ACC = 5'h07,
        OP_INC = 5'h08, OP_INCREMENT_TO_ACC = 5'h09, OP_HALT = 5'h0a, OP_JMP = 5'h0b,
        OP_MOV_AX = 5'h0c, OP_MOV_AM = 5'h0d, OP_MOV_MA = 5'h0e, OP_OR_AM = 5'h0f,
        OP_OR_AX = 5'h10, OP_ORM = 5'h11, OP_RET = 5'h12, OP_RET_AX = 5'h13,
        OP_INTERRUPT_RETURN_OP = 5'h14, OP_RL = 5'h15, OP_RLA = 5'h16
    } mie_op_e;
    typedef enum logic [1:0] {ST_RUN = 2'b01, ST_HALT = 2'b10} mie_state_e;
    typedef struct packed {
        logic [10:0] rsv;
        mie_op_e     op;
        logic [7:0]  addr;
        logic [7:0]  imm;
    } mie_instr_s;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mie_apb_req_s;
endpackage : mie_pkg

// file: mie_core.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module mie_core #(
    parameter int MEM_DEPTH   = 16,
    parameter int STACK_DEPTH = 8,
    parameter int PC_WIDTH    = 14,
    parameter int PRESC_WIDTH = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire mie_pkg::mie_apb_req_s apb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              wake_pin,
    output logic                   clk_run_en,
    output logic                   wdt_timeout
);
    import mie_pkg::*;

    localparam int MIW = $clog2(MEM_DEPTH);
    localparam int SPW = $clog2(STACK_DEPTH);

    initial
    begin
        if (MEM_DEPTH < 2 || MEM_DEPTH > 64 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
            $error("MEM_DEPTH must be a power of two from 2 to 64");
        if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
            $error("STACK_DEPTH must be a power of two of at least 2");
        if (PC_WIDTH < 1 || PC_WIDTH > 16)
            $error("PC_WIDTH must be 1 to 16");
    end

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    function automatic logic is_ret(input mie_op_e o);
        return o == OP_RET || o == OP_RET_AX || o == OP_INTERRUPT_RETURN_OP;
    endfunction : is_ret

    logic [7:0]          acc;
    logic [7:0]          mem [MEM_DEPTH];
    logic [PC_WIDTH-1:0] pc;
    logic [PC_WIDTH-1:0] stk [STACK_DEPTH];
    logic [SPW-1:0]      sp;
    logic                f_c, f_ac, f_z, f_to, f_pdf, f_emi;
    logic                pre_a, pre_b;
    logic [7:0]          wdt_cnt;
    logic [PRESC_WIDTH-1:0] presc;
    mie_state_e          state;
    logic                wait_done;
    logic                wake_s1, wake_s2;

    mie_instr_s          ins;
    logic                acc_phase, wr_acc, instr_wr, fire, mapped, is_mem;
    logic [MIW-1:0]      mem_idx, win_idx;
    logic [7:0]          m;
    logic [7:0]          next_acc, next_mem;
    logic                we_acc, we_mem, z_upd, next_c, c_upd;
    logic                do_pop, do_jmp, do_halt, do_clear;
    logic                wdt_ovf;
    logic [3:0]          daa_lo, daa_hi;
    logic                ac1;
    logic [4:0]          hi_sum;

    assign ins       = mie_instr_s'(apb.pwdata);
    assign acc_phase = apb.psel && apb.penable;
    assign is_mem    = apb.paddr >= OFS_MEM && apb.paddr < OFS_MEM + 12'(MEM_DEPTH * 4);
    assign win_idx   = MIW'((apb.paddr - OFS_MEM) >> 2);
    assign mapped    = is_mem || apb.paddr == OFS_INSTR || apb.paddr == OFS_ACC
                       || apb.paddr == OFS_FLAGS || apb.paddr == OFS_PC || apb.paddr == OFS_PUSH;
    assign instr_wr  = acc_phase && apb.pwrite && apb.paddr == OFS_INSTR;
    // A return holds the bus for one extra cycle, so it spans two instruction cycles.
    assign pready    = !(instr_wr && state == ST_RUN && is_ret(ins.op) && !wait_done);
    // Instructions are refused while powered down; the core clock is off then.
    assign pslverr   = acc_phase && (!mapped || (instr_wr && state != ST_RUN));
    assign wr_acc    = acc_phase && pready && apb.pwrite && !pslverr;
    assign fire      = wr_acc && apb.paddr == OFS_INSTR;
    assign mem_idx   = ins.addr[MIW-1:0];
    assign m         = mem[mem_idx];
    assign clk_run_en = state == ST_RUN;
    assign wdt_ovf   = &presc && &wdt_cnt;

    always_comb
    begin
        next_acc = acc;
        next_mem = m;
        we_acc   = 1'b0;
        we_mem   = 1'b0;
        z_upd    = 1'b0;
        c_upd    = 1'b0;
        next_c   = f_c;
        do_pop   = 1'b0;
        do_jmp   = 1'b0;
        do_halt  = 1'b0;
        hi_sum   = 5'h00;
        ac1      = 1'b0;
        daa_lo   = acc[3:0];
        daa_hi   = acc[7:4];
        case (ins.op)
            OP_CPL:    begin next_mem = ~m; we_mem = 1'b1; z_upd = 1'b1; end
            OP_ONES_COMPLEMENT_TO_ACC:   begin next_acc = ~m; we_acc = 1'b1; z_upd = 1'b1; end
            OP_DAA:
            begin
                if (acc[3:0] > BCD_MAX || f_ac)
                begin
                    daa_lo = acc[3:0] + BCD_FIX;
                    ac1    = !f_ac;
                end
                hi_sum = {1'b0, acc[7:4]} + {4'h0, ac1};
                if (hi_sum > {1'b0, BCD_MAX} || f_c)
                begin
                    daa_hi = 4'(hi_sum + {1'b0, BCD_FIX});
                    next_c = 1'b1;
                end
                else
                    daa_hi = hi_sum[3:0];
                next_mem = {daa_hi, daa_lo};
                we_mem   = 1'b1;
                c_upd    = 1'b1;
            end
            OP_DEC:    begin next_mem = m - 8'h01; we_mem = 1'b1; z_upd = 1'b1; end
            OP_DECREMENT_TO_ACC:   begin next_acc = m - 8'h01; we_acc = 1'b1; z_upd = 1'b1; end
            OP_INC:    begin next_mem = m + 8'h01; we_mem = 1'b1; z_upd = 1'b1; end
            OP_INCREMENT_TO_ACC:   begin next_acc = m + 8'h01; we_acc = 1'b1; z_upd = 1'b1; end
            OP_HALT:   do_halt = 1'b1;
            OP_JMP:    do_jmp = 1'b1;
            OP_MOV_AX: begin next_acc = ins.imm; we_acc = 1'b1; end
            OP_MOV_AM: begin next_acc = m; we_acc = 1'b1; end
            OP_MOV_MA: begin next_mem = acc; we_mem = 1'b1; end
            OP_OR_AM:  begin next_acc = acc | m; we_acc = 1'b1; z_upd = 1'b1; end
            OP_OR_AX:  begin next_acc = acc | ins.imm; we_acc = 1'b1; z_upd = 1'b1; end
            OP_ORM:    begin next_mem = acc | m; we_mem = 1'b1; z_upd = 1'b1; end
            OP_RET:    do_pop = 1'b1;
            OP_RET_AX: begin do_pop = 1'b1; next_acc = ins.imm; we_acc = 1'b1; end
            OP_INTERRUPT_RETURN_OP:   do_pop = 1'b1;
            OP_RL:     begin next_mem = {m[6:0], m[7]}; we_mem = 1'b1; end
            OP_RLA:    begin next_acc = {m[6:0], m[7]}; we_acc = 1'b1; end
            default:   ;
        endcase
    end

    // Clearing happens on the instruction that completes the pair.
    assign do_clear = fire && ((ins.op == OP_PRE_A && pre_b) || (ins.op == OP_PRE_B && pre_a));

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            acc <= 8'h00;
        else if (fire && we_acc)
            acc <= next_acc;
        else if (wr_acc && apb.paddr == OFS_ACC)
            acc <= apb.pwdata[7:0];
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            for (int i = 0; i < MEM_DEPTH; i++)
                mem[i] <= 8'h00;
        else if (fire && we_mem)
            mem[mem_idx] <= next_mem;
        else if (wr_acc && is_mem)
            mem[win_idx] <= apb.pwdata[7:0];
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            f_c   <= 1'b0;
            f_ac  <= 1'b0;
            f_z   <= 1'b0;
            f_emi <= 1'b0;
        end
        else if (fire)
        begin
            if (z_upd)
                f_z <= is_zero(we_mem ? next_mem : next_acc);
            if (c_upd)
                f_c <= next_c;
            if (ins.op == OP_INTERRUPT_RETURN_OP)
                f_emi <= 1'b1;
        end
        else if (wr_acc && apb.paddr == OFS_FLAGS)
        begin
            f_c   <= apb.pwdata[FB_C];
            f_ac  <= apb.pwdata[FB_AC];
            f_z   <= apb.pwdata[FB_Z];
            f_emi <= apb.pwdata[FB_EMI];
        end
    end

    // The stack is circular: a push past the top overwrites the oldest entry.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pc <= '0;
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stk[i] <= '0;
        end
        else if (fire)
        begin
            if (do_pop)
            begin
                pc <= stk[sp - SPW'(1)];
                sp <= sp - SPW'(1);
            end
            else if (do_jmp)
                pc <= PC_WIDTH'({ins.addr, ins.imm});
            else
                pc <= pc + PC_WIDTH'(1);
        end
        else if (wr_acc && apb.paddr == OFS_PC)
            pc <= apb.pwdata[PC_WIDTH-1:0];
        else if (wr_acc && apb.paddr == OFS_PUSH)
        begin
            stk[sp] <= apb.pwdata[PC_WIDTH-1:0];
            sp      <= sp + SPW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            wait_done <= 1'b0;
        else if (acc_phase && pready)
            wait_done <= 1'b0;
        else if (instr_wr && state == ST_RUN && is_ret(ins.op))
            wait_done <= 1'b1;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pre_a <= 1'b0;
            pre_b <= 1'b0;
        end
        else if (do_clear)
        begin
            pre_a <= 1'b0;
            pre_b <= 1'b0;
        end
        else if (fire && ins.op == OP_PRE_A)
            pre_a <= 1'b1;
        else if (fire && ins.op == OP_PRE_B)
            pre_b <= 1'b1;
    end

    // The watchdog keeps counting during power-down so that it can wake the core.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            presc   <= '0;
            wdt_cnt <= 8'h00;
        end
        else if (fire && do_halt)
        begin
            presc   <= '0;
            wdt_cnt <= 8'h00;
        end
        else if (do_clear)
            wdt_cnt <= 8'h00;
        else
        begin
            presc <= presc + PRESC_WIDTH'(1);
            if (&presc)
                wdt_cnt <= wdt_cnt + 8'h01;
        end
    end

    // A timeout in the same cycle as a clear wins, so it is never lost.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            f_to        <= 1'b0;
            f_pdf       <= 1'b0;
            wdt_timeout <= 1'b0;
        end
        else
        begin
            wdt_timeout <= wdt_ovf;
            if (wdt_ovf)
                f_to <= 1'b1;
            else if (do_clear || (fire && do_halt))
                f_to <= 1'b0;
            if (fire && do_halt)
                f_pdf <= 1'b1;
            else if (do_clear)
                f_pdf <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end
        else
        begin
            wake_s1 <= wake_pin;
            wake_s2 <= wake_s1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            state <= ST_RUN;
        else
            case (state)
                ST_RUN:  if (fire && do_halt) state <= ST_HALT;
                ST_HALT: if (wake_s2 || wdt_ovf) state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (apb.psel && !apb.penable && !apb.pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (is_mem)
                prdata <= {24'h00_0000, mem[win_idx]};
            else if (apb.paddr == OFS_ACC)
                prdata <= {24'h00_0000, acc};
            else if (apb.paddr == OFS_PC)
                prdata <= 32'(pc);
            else if (apb.paddr == OFS_FLAGS)
            begin
                prdata[FB_C]     <= f_c;
                prdata[FB_AC]    <= f_ac;
                prdata[FB_Z]     <= f_z;
                prdata[FB_TO]    <= f_to;
                prdata[FB_PDF]   <= f_pdf;
                prdata[FB_EMI]   <= f_emi;
                prdata[FB_PRE_A] <= pre_a;
                prdata[FB_PRE_B] <= pre_b;
                prdata[FB_HALT]  <= state == ST_HALT;
            end
        end
    end

    // Helper capture of the operands seen in the previous cycle; h_fire marks when they belong to an executed instruction.
    logic       h_fire;
    mie_op_e    h_op;
    logic [7:0] h_m;
    logic [MIW-1:0] h_idx;
    logic [PC_WIDTH-1:0] h_pc;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            h_fire <= 1'b0;
            h_op   <= OP_NOP;
            h_m    <= 8'h00;
            h_idx  <= '0;
            h_pc   <= '0;
        end
        else
        begin
            h_fire <= fire;
            h_op   <= ins.op;
            h_m    <= m;
            h_idx  <= mem_idx;
            h_pc   <= pc;
        end
    end

    property p_preclear_pair;
        @(posedge clk_sys) disable iff (reset)
        fire && ins.op == OP_PRE_B && pre_a |=> wdt_cnt == 8'h00 && !f_pdf && !pre_a && !pre_b;
    endproperty
    a_preclear_pair: assert property (p_preclear_pair) else $error("pair preclear failed");
    property p_preclear_single;
        @(posedge clk_sys) disable iff (reset)
        fire && ins.op == OP_PRE_A && !pre_b |=> pre_a && f_pdf == $past(f_pdf) && f_to == $past(f_to);
    endproperty
    a_preclear_single: assert property (p_preclear_single) else $error("single preclear changed flags");
    property p_cpl_mem;
        @(posedge clk_sys) disable iff (reset)
        h_fire && h_op == OP_CPL |-> mem[h_idx] == ~h_m && f_z == (h_m == 8'hff) && f_c == $past(f_c);
    endproperty
    a_cpl_mem: assert property (p_cpl_mem) else $error("complement result wrong");
    property p_halt;
        @(posedge clk_sys) disable iff (reset)
        fire && ins.op == OP_HALT |=> f_pdf && !clk_run_en && wdt_cnt == 8'h00 && pc == h_pc + PC_WIDTH'(1);
    endproperty
    a_halt: assert property (p_halt) else $error("power-down entry wrong");
    property p_jmp;
        @(posedge clk_sys) disable iff (reset)
        fire && ins.op == OP_JMP |=> pc == PC_WIDTH'({$past(ins.addr), $past(ins.imm)}) && f_z == $past(f_z);
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");
    property p_ret_wait;
        @(posedge clk_sys) disable iff (reset)
        instr_wr && state == ST_RUN && is_ret(ins.op) && !wait_done |-> !pready ##1 pready;
    endproperty
    a_ret_wait: assert property (p_ret_wait) else $error("return not two cycles");
    property p_interrupt_return_op;
        @(posedge clk_sys) disable iff (reset)
        fire && ins.op == OP_INTERRUPT_RETURN_OP |=> f_emi && sp == $past(sp) - SPW'(1);
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return wrong");
    property p_rla;
        @(posedge clk_sys) disable iff (reset)
        h_fire && h_op == OP_RLA |-> acc == {h_m[6:0], h_m[7]} && mem[h_idx] == h_m && f_z == $past(f_z);
    endproperty
    a_rla: assert property (p_rla) else $error("rotate to accumulator wrong");
    property p_increment_to_acc_zero;
        @(posedge clk_sys) disable iff (reset)
        h_fire && h_op == OP_INCREMENT_TO_ACC |-> f_z == (acc == 8'h00) && acc == h_m + 8'h01;
    endproperty
    a_increment_to_acc_zero: assert property (p_increment_to_acc_zero) else $error("increment zero flag wrong");
endmodule : mie_core

// file: mcu_instruction_execute_subset_bench.sv
`timescale 1ns/100ps
module mcu_instruction_execute_subset_bench;
    import mie_pkg::*;
    typedef struct {
        logic        rd;
        logic        err;
        logic [31:0] data;
        int          cyc;
    } mie_note_s;
    logic         clk_sys;
    logic         reset;
    mie_apb_req_s apb;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         wake_pin;
    logic         clk_run_en;
    logic         wdt_timeout;
    mie_note_s    notes[$];
    mie_note_s    note;
    int           mismatches;
    int           checked;
    int           access_cycles;
    int           seed;
    int           n;
    logic [31:0]  r;
    logic [31:0]  f;
    logic [7:0]   m_acc;
    logic [7:0]   m_mem[16];
    logic [13:0]  m_pc;
    logic [13:0]  m_stk[$];
    logic         m_c, m_ac, m_z, m_to, m_pdf, m_emi, m_pa, m_pb, m_halt;
    // Entries are opcode, memory byte, accumulator, flags.
    logic [31:0]  dir_cases[10] = '{32'h08ff0000, 32'h09ff1200, 32'h06010000, 32'h07000004, 32'h05009a00,
                                    32'h05003902, 32'h05004501, 32'h03ff0000, 32'h11000000, 32'h15800007};

    mie_core #(.PRESC_WIDTH(8)) mie_core_i (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .apb         (apb),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .wake_pin    (wake_pin),
        .clk_run_en  (clk_run_en),
        .wdt_timeout (wdt_timeout)
    );

    always #2 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Every completed transfer consumes one note, so a lost or extra completion shows up too.
    always @(posedge clk_sys)
    begin
        if (apb.psel && apb.penable)
        begin
            access_cycles++;
            if (pready === 1'b1)
            begin
                if (notes.size() == 0)
                    check(32'h1, 32'h0);
                else
                begin
                    note = notes.pop_front();
                    check({31'h0, pslverr}, {31'h0, note.err});
                    if (note.rd)
                        check(prdata, note.data);
                    check(access_cycles, note.cyc);
                end
                access_cycles = 0;
            end
        end
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic rd, input logic err, input logic [31:0] exp, input int cyc);
        notes.push_back('{rd, err, exp, cyc});
        @(posedge clk_sys);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb.penable <= 1'b1;
        // Only the watchdog process ends a wait that never completes.
        do
            @(negedge clk_sys);
        while (pready !== 1'b1);
        @(posedge clk_sys);
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0, 1'b0, 32'h0, 1);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 1'b1, 1'b0, exp, 1);
    endtask : rd

    function automatic logic [11:0] maddr(input logic [3:0] i);
        return OFS_MEM + {6'h0, i, 2'b00};
    endfunction : maddr

    function automatic logic [31:0] m_flags();
        return {21'h0, m_halt, m_pb, m_pa, 1'b0, m_emi, m_pdf, m_to, 1'b0, m_z, m_ac, m_c};
    endfunction : m_flags

    task automatic model(input logic [4:0] code, input logic [7:0] ad, input logic [7:0] x);
        logic [7:0] v;
        logic [7:0] res;
        logic [4:0] lo;
        logic [4:0] hi;
        logic       ac1;
        v = m_mem[ad[3:0]];
        res = 8'h00;
        m_pc = m_pc + 14'h1;
        case (code)
            5'h01: m_pa = 1'b1;
            5'h02: m_pb = 1'b1;
            5'h03, 5'h04: res = ~v;
            5'h05:
            begin
                lo = {1'b0, m_acc[3:0]};
                ac1 = 1'b0;
                if (lo > 5'h09 || m_ac)
                begin
                    lo = lo + 5'h06;
                    ac1 = ~m_ac;
                end
                hi = {1'b0, m_acc[7:4]} + {4'h0, ac1};
                if (hi > 5'h09 || m_c)
                begin
                    hi = hi + 5'h06;
                    m_c = 1'b1;
                end
                m_mem[ad[3:0]] = {hi[3:0], lo[3:0]};
            end
            5'h06, 5'h07: res = v - 8'h01;
            5'h08, 5'h09: res = v + 8'h01;
            5'h0a:
            begin
                m_pdf = 1'b1;
                m_to = 1'b0;
                m_halt = 1'b1;
            end
            5'h0b: m_pc = {ad[5:0], x};
            5'h0c, 5'h13: res = x;
            5'h0d: res = v;
            5'h0e: res = m_acc;
            5'h0f, 5'h11: res = m_acc | v;
            5'h10: res = m_acc | x;
            5'h15, 5'h16: res = {v[6:0], v[7]};
            default: ;
        endcase
        if (code inside {[5'h12:5'h14]})
            m_pc = m_stk.pop_back();
        if (code == 5'h14)
            m_emi = 1'b1;
        if (m_pa && m_pb)
        begin
            m_pa = 1'b0;
            m_pb = 1'b0;
            m_to = 1'b0;
            m_pdf = 1'b0;
        end
        if (code inside {5'h03, 5'h06, 5'h08, 5'h0e, 5'h11, 5'h15})
            m_mem[ad[3:0]] = res;
        if (code inside {5'h04, 5'h07, 5'h09, 5'h0c, 5'h0d, 5'h0f, 5'h10, 5'h13, 5'h16})
            m_acc = res;
        if (code inside {[5'h03:5'h04], [5'h06:5'h09], [5'h0f:5'h11]})
            m_z = (res == 8'h00);
    endtask : model

    task automatic run(input logic [4:0] code, input logic [7:0] ad, input logic [7:0] x);
        xfer(1'b1, OFS_INSTR, {11'h0, code, ad, x}, 1'b0, 1'b0, 32'h0,
             (code inside {[5'h12:5'h14]}) ? 2 : 1);
        model(code, ad, x);
    endtask : run

    task automatic verify(input logic [3:0] i);
        rd(OFS_ACC, {24'h0, m_acc});
        rd(OFS_FLAGS, m_flags());
        rd(OFS_PC, {18'h0, m_pc});
        rd(maddr(i), {24'h0, m_mem[i]});
    endtask : verify

    task automatic trial(input logic [4:0] code, input logic [7:0] ad, input logic [7:0] x,
                         input logic [7:0] acc, input logic [31:0] fl, input logic [7:0] mv, input logic [13:0] ret);
        wr(OFS_ACC, {24'h0, acc});
        m_acc = acc;
        wr(OFS_FLAGS, fl);
        m_c = fl[0];
        m_ac = fl[1];
        m_z = fl[2];
        m_emi = fl[6];
        wr(maddr(ad[3:0]), {24'h0, mv});
        m_mem[ad[3:0]] = mv;
        if (code inside {[5'h12:5'h14]})
        begin
            wr(OFS_PUSH, {18'h0, ret});
            m_stk.push_back(ret);
        end
        run(code, ad, x);
        verify(ad[3:0]);
    endtask : trial

    initial
    begin
        clk_sys = 1'b0;
        reset = 1'b1;
        apb = '0;
        wake_pin = 1'b0;
        seed = 5;
        mismatches = 0;
        checked = 0;
        access_cycles = 0;
        {m_acc, m_pc, m_c, m_ac, m_z, m_to, m_pdf, m_emi, m_pa, m_pb, m_halt} = '0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(OFS_ACC, 32'h0);
        rd(OFS_FLAGS, 32'h0);
        rd(OFS_PC, 32'h0);
        check({31'h0, clk_run_en}, 32'h1);
        $display("test reset done");
        xfer(1'b0, 12'h014, 32'h0, 1'b1, 1'b1, 32'h0, 1);
        xfer(1'b1, 12'h0f0, 32'h5a, 1'b0, 1'b1, 32'h0, 1);
        $display("test unmapped done");
        foreach (dir_cases[k])
            trial(dir_cases[k][28:24], 8'h3c, 8'h00, dir_cases[k][15:8], {24'h0, dir_cases[k][7:0]},
                  dir_cases[k][23:16], 14'h0);
        $display("test directed done");
        // Codes above the last opcode must behave as a no-op.
        for (int i = 0; i < 128; i++)
        begin
            r = $random(seed);
            f = $random(seed);
            if (i[4:0] != 5'h0a)
                trial(i[4:0], r[7:0], r[15:8], r[23:16], f, f[15:8], f[29:16]);
        end
        $display("test random done");
        run(5'h01, 8'h00, 8'h00);
        run(5'h02, 8'h00, 8'h00);
        run(5'h0a, 8'h05, 8'h00);
        @(negedge clk_sys);
        check({31'h0, clk_run_en}, 32'h0);
        verify(4'h5);
        xfer(1'b1, OFS_INSTR, {11'h0, 5'h08, 8'h05, 8'h00}, 1'b0, 1'b1, 32'h0, 1);
        verify(4'h5);
        wake_pin <= 1'b1;
        n = 0;
        while (clk_run_en !== 1'b1 && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        check({31'h0, clk_run_en}, 32'h1);
        @(posedge clk_sys);
        wake_pin <= 1'b0;
        m_halt = 1'b0;
        verify(4'h5);
        $display("test halt done");
        run(5'h0a, 8'h05, 8'h00);
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 70000)
        begin
            @(negedge clk_sys);
            n++;
        end
        check({31'h0, n >= 65530 && n <= 65545}, 32'h1);
        @(negedge clk_sys);
        check({31'h0, wdt_timeout}, 32'h0);
        m_to = 1'b1;
        m_halt = 1'b0;
        verify(4'h5);
        run(5'h01, 8'h05, 8'h00);
        verify(4'h5);
        run(5'h02, 8'h05, 8'h00);
        verify(4'h5);
        $display("test watchdog done");
        tally_and_finish();
    end

    // The span covers the full watchdog period plus the register traffic around it.
    initial
    begin
        #360000;
        mismatches++;
        tally_and_finish();
    end
endmodule : mcu_instruction_execute_subset_bench
